// file: rtl/qsfc_regs.sv
// Purpose: Register block of a quad serial flash controller on APB
// Assumes: Serial engine runs on ref_clk; sck_in comes from the pin side
// Notes:   No wait state; pready is high in every access cycle
//
// How it works
// - Chip select gap is field plus one
// - Receive ready: queue full, or final data while words are held
// - Transmit ready: queue nearly empty, resets high
// - Receive request at selected held level
// - Transmit request at selected free level
// - Done interrupt only when enable is one
// - DMA requests driven only while enabled
// - Done flag set when command finishes
// - Store returned flash status byte
// - Mask system address for direct reads
// - Data port pushes transmit, pops receive
//
// The APB slave port was left to the implementer.
`include "qsfc_map.svh"
`default_nettype none

module qsfc_regs
	import qsfc_pkg::*;
#(
	parameter int DEPTH = `QSFC_FIFO_DEPTH,
	parameter int CW    = $clog2(`QSFC_FIFO_DEPTH + 1)
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Interrupt and DMA handshake
	output logic             irq,
	output logic             dma_rx_req,
	output logic             dma_tx_req,
	// Serial engine side, same clock
	input  wire logic        cmd_done,
	input  wire logic        status_valid,
	input  wire logic [7:0]  status_byte,
	input  wire logic        final_data,
	input  wire logic        rx_push,
	input  wire logic [31:0] rx_data,
	output logic             rx_full,
	input  wire logic        tx_pop,
	output logic [31:0]      tx_data,
	output logic             tx_empty,
	input  wire logic        cs_request,
	output logic             cs_granted,
	// Pin side
	input  wire logic        sck_in,
	output logic             cs_n,
	// Direct mapping
	input  wire logic [31:0] sys_addr,
	output logic [31:0]      flash_addr
);

	// ---------------------------------------------------------------
	// Helper: trigger level code to word count
	// ---------------------------------------------------------------
	// Reserved code maps to a count no queue can reach, so it never fires
	function automatic logic [CW:0] qsfc_level_words(input qsfc_level_type code);
		logic [CW:0] words;
		words = '0;
		unique case (code)
			QSFC_LVL_8:        words = (CW+1)'(`QSFC_LEVEL_STEP);
			QSFC_LVL_16:       words = (CW+1)'(2 * `QSFC_LEVEL_STEP);
			QSFC_LVL_24:       words = (CW+1)'(3 * `QSFC_LEVEL_STEP);
			QSFC_LVL_RESERVED: words = (CW+1)'(DEPTH + 1);
		endcase
		return words;
	endfunction : qsfc_level_words

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [`QSFC_GAP_MSB:0] cs_gap;         // Gap field
	logic                   dma_enable;     // Handshake enable
	logic                   cmd_done_irq_enable;  // Done interrupt enable
	qsfc_level_type         rx_trigger_level;     // Receive trigger code
	qsfc_level_type         tx_trigger_level;     // Transmit trigger code
	logic                   cmd_done_flag;  // Sticky done flag
	logic [7:0]             flash_status;   // Last flash status byte
	logic [31:0]            address_trim;   // Direct map mask
	logic                   rx_queue_ready; // Receive ready flag
	logic                   tx_queue_ready; // Transmit ready flag
	logic [31:0]            rd_word;        // Read data captured at setup
	logic                   rd_err;         // Error captured at setup
	logic                   sck_meta;       // Synchroniser stage one
	logic                   sck_sync;       // Synchroniser stage two
	logic                   sck_prev;       // Edge detect history
	logic [4:0]             gap_count;      // Serial periods seen while deselected
	qsfc_cs_type            cs_state;       // Chip select sequencer
	qsfc_cs_type            next_cs_state;  // Its next value

	// Queue bundles
	qsfc_fifo_if #(.WIDTH(32), .CW(CW)) txq ();
	qsfc_fifo_if #(.WIDTH(32), .CW(CW)) rxq ();

	qsfc_fifo #(.WIDTH(32), .DEPTH(DEPTH), .CW(CW)) u_txq (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.port    (txq)
	);

	qsfc_fifo #(.WIDTH(32), .DEPTH(DEPTH), .CW(CW)) u_rxq (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.port    (rxq)
	);

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	wire setup_phase  = psel & ~penable;
	wire access_phase = psel & penable;
	wire wr_access    = access_phase & pwrite;
	wire rd_access    = access_phase & ~pwrite;

	wire hit_gap    = (paddr == `QSFC_OFS_CS_GAP_TIMING);
	wire hit_state  = (paddr == `QSFC_OFS_FIFO_STATE);
	wire hit_ctrl   = (paddr == `QSFC_OFS_IRQ_CONTROL);
	wire hit_flags  = (paddr == `QSFC_OFS_IRQ_FLAGS);
	wire hit_status = (paddr == `QSFC_OFS_FLASH_STATUS_VALUE);
	wire hit_trim   = (paddr == `QSFC_OFS_ADDRESS_TRIM);
	wire hit_data   = (paddr == `QSFC_OFS_DATA_WINDOW);
	wire hit_levels = (paddr == `QSFC_OFS_FIFO_LEVELS);
	wire hit_any    = hit_gap | hit_state | hit_ctrl | hit_flags | hit_status
	                | hit_trim | hit_data | hit_levels;

	// Read-only words take no write; such a write reports an error
	wire hit_ro     = hit_state | hit_status | hit_levels;

	// Data port: writes fill transmit, reads drain receive
	assign txq.push      = wr_access & hit_data & ~txq.full;
	assign txq.push_data = pwdata;
	assign rxq.pop       = rd_access & hit_data & ~rxq.empty;

	// Engine side of the queues
	assign rxq.push      = rx_push;
	assign rxq.push_data = rx_data;
	assign txq.pop       = tx_pop;
	assign tx_data       = txq.pop_data;
	assign tx_empty      = txq.empty;
	assign rx_full       = rxq.full;

	// Free room in the transmit queue
	wire [CW:0] tx_free = (CW+1)'(DEPTH) - {1'b0, txq.count};
	wire [CW:0] rx_held = {1'b0, rxq.count};

	// ---------------------------------------------------------------
	// Read mux, sampled in the setup cycle
	// ---------------------------------------------------------------
	// Capturing here keeps prdata a flop output without adding a wait state
	wire [31:0] fifo_state_word = {30'h0, rx_queue_ready, tx_queue_ready};
	wire [31:0] ctrl_word = {18'h0, rx_trigger_level, 2'h0, tx_trigger_level,
	                         6'h0, cmd_done_irq_enable, dma_enable};
	wire [31:0] levels_word = {10'h0, 6'(txq.count), 10'h0, 6'(rxq.count)};
	wire [31:0] next_rd_word =
		hit_gap    ? {28'h0, cs_gap} :
		hit_state  ? fifo_state_word :
		hit_ctrl   ? ctrl_word :
		hit_flags  ? {31'h0, cmd_done_flag} :
		hit_status ? {24'h0, flash_status} :
		hit_trim   ? address_trim :
		hit_data   ? (rxq.empty ? 32'h0 : rxq.pop_data) :
		hit_levels ? levels_word :
		32'h0;
	// Unmapped, write to read-only, push when full, pop when empty
	wire next_rd_err = ~hit_any
	                 | (pwrite & hit_ro)
	                 | (pwrite & hit_data & txq.full)
	                 | (~pwrite & hit_data & rxq.empty);

	// Read word and error latched in setup
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_word <= 32'h0;
			rd_err  <= 1'b0;
		end else if (setup_phase) begin
			rd_word <= next_rd_word;
			rd_err  <= next_rd_err;
		end
	end

	assign pready  = access_phase;
	assign prdata  = rd_word;
	assign pslverr = access_phase & rd_err;

	// ---------------------------------------------------------------
	// Software writable registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cs_gap              <= `QSFC_RST_CS_GAP;
			dma_enable          <= 1'b0;
			cmd_done_irq_enable <= 1'b0;
			rx_trigger_level    <= QSFC_LVL_8;
			tx_trigger_level    <= QSFC_LVL_8;
			address_trim        <= `QSFC_RST_ADDRESS_TRIM;
		end else if (wr_access) begin
			if (hit_gap) begin
				cs_gap <= pwdata[`QSFC_GAP_MSB:0];
			end
			if (hit_ctrl) begin
				dma_enable          <= pwdata[`QSFC_DMA_EN_BIT];
				cmd_done_irq_enable <= pwdata[`QSFC_DONE_IRQ_EN_BIT];
				rx_trigger_level    <=
					qsfc_level_type'(pwdata[`QSFC_RX_LEVEL_MSB:`QSFC_RX_LEVEL_LSB]);
				tx_trigger_level    <=
					qsfc_level_type'(pwdata[`QSFC_TX_LEVEL_MSB:`QSFC_TX_LEVEL_LSB]);
			end
			if (hit_trim) begin
				address_trim <= pwdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Done flag and interrupt
	// ---------------------------------------------------------------
	// Writing zero clears; a completion in the same cycle wins
	wire done_clear = wr_access & hit_flags & ~pwdata[`QSFC_DONE_FLAG_BIT];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmd_done_flag <= 1'b0;
		end else if (cmd_done) begin
			cmd_done_flag <= 1'b1;
		end else if (done_clear) begin
			cmd_done_flag <= 1'b0;
		end
	end

	// Level output, no masking other than the enable
	assign irq = cmd_done_flag & cmd_done_irq_enable;

	// ---------------------------------------------------------------
	// Flash status capture
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flash_status <= 8'h00;
		end else if (status_valid) begin
			flash_status <= status_byte;
		end
	end

	// ---------------------------------------------------------------
	// Queue ready flags
	// ---------------------------------------------------------------
	// Receive: full, or the engine says what is left is the tail
	wire next_rx_ready = rxq.full | (final_data & ~rxq.empty);
	// Transmit: at most one word left, so software may fill it whole
	wire next_tx_ready = (txq.count <= CW'(1));

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_queue_ready <= 1'b0;
			tx_queue_ready <= 1'b1;
		end else begin
			rx_queue_ready <= next_rx_ready;
			tx_queue_ready <= next_tx_ready;
		end
	end

	// ---------------------------------------------------------------
	// DMA handshake
	// ---------------------------------------------------------------
	// Combinational so a request drops the cycle the level is left
	wire rx_at_level = (rx_held >= qsfc_level_words(rx_trigger_level));
	wire tx_at_level = (tx_free >= qsfc_level_words(tx_trigger_level));
	assign dma_rx_req = dma_enable & rx_at_level;
	assign dma_tx_req = dma_enable & tx_at_level;

	// ---------------------------------------------------------------
	// Direct mapping
	// ---------------------------------------------------------------
	// A one in the mask keeps the bit; zeros strip high order bits
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flash_addr <= 32'h0;
		end else begin
			flash_addr <= sys_addr & address_trim;
		end
	end

	// ---------------------------------------------------------------
	// Serial clock sampling
	// ---------------------------------------------------------------
	// Two stages before anything looks at the pin
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sck_meta <= 1'b0;
			sck_sync <= 1'b0;
			sck_prev <= 1'b0;
		end else begin
			sck_meta <= sck_in;
			sck_sync <= sck_meta;
			sck_prev <= sck_sync;
		end
	end

	wire sck_rise = sck_sync & ~sck_prev;

	// ---------------------------------------------------------------
	// Chip select gap sequencer
	// ---------------------------------------------------------------
	// Gap is met once field plus one serial periods passed deselected
	wire [4:0] gap_needed = {1'b0, cs_gap} + 5'h01;
	wire       gap_met    = (gap_count >= gap_needed);

	always_comb begin
		next_cs_state = cs_state;
		unique case (cs_state)
			QSFC_CS_GAP:   if (gap_met) begin
				next_cs_state = QSFC_CS_READY;
			end
			QSFC_CS_READY: if (cs_request) begin
				next_cs_state = QSFC_CS_ON;
			end
			QSFC_CS_ON:    if (!cs_request) begin
				next_cs_state = QSFC_CS_GAP;
			end
			default:       next_cs_state = QSFC_CS_GAP;
		endcase
	end

	// Counter restarts on each deselect and saturates at 16
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cs_state  <= QSFC_CS_READY;
			gap_count <= 5'h10;
		end else begin
			cs_state <= next_cs_state;
			if (cs_state == QSFC_CS_ON) begin
				gap_count <= 5'h00;
			end else if (sck_rise && gap_count != 5'h10) begin
				gap_count <= gap_count + 5'h01;
			end
		end
	end

	// Select pin low only while granted
	assign cs_n       = (cs_state != QSFC_CS_ON);
	assign cs_granted = (cs_state == QSFC_CS_ON);

endmodule : qsfc_regs

`default_nettype wire

// file: include/qsfc_map.svh
// Purpose: Offsets, field positions, reset values and counts of the flash register block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef QSFC_MAP_SVH
`define QSFC_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define QSFC_OFS_CS_GAP_TIMING       12'h014
`define QSFC_OFS_FIFO_STATE          12'h018
`define QSFC_OFS_IRQ_CONTROL         12'h020
`define QSFC_OFS_IRQ_FLAGS           12'h024
`define QSFC_OFS_FLASH_STATUS_VALUE  12'h028
`define QSFC_OFS_ADDRESS_TRIM        12'h02C
`define QSFC_OFS_DATA_WINDOW         12'h100
`define QSFC_OFS_FIFO_LEVELS         12'h030

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define QSFC_GAP_MSB                 3
`define QSFC_RX_READY_BIT            1
`define QSFC_TX_READY_BIT            0
`define QSFC_RX_LEVEL_MSB            13
`define QSFC_RX_LEVEL_LSB            12
`define QSFC_TX_LEVEL_MSB            9
`define QSFC_TX_LEVEL_LSB            8
`define QSFC_DONE_IRQ_EN_BIT         1
`define QSFC_DMA_EN_BIT              0
`define QSFC_DONE_FLAG_BIT           0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define QSFC_RST_CS_GAP              4'hF
`define QSFC_RST_IRQ_CONTROL         32'h0000_0000
`define QSFC_RST_ADDRESS_TRIM        32'h0000_0000

// ---------------------------------------------------------------
// Sizes and counts
// ---------------------------------------------------------------
`define QSFC_FIFO_DEPTH              32
`define QSFC_LEVEL_STEP              8

`endif

// file: include/qsfc_pkg.sv
// Purpose: Types shared by the flash register block
// Assumes: Nothing beyond the map header
// Notes:   Codes are written out in binary
`default_nettype none

package qsfc_pkg;

	// Trigger level codes for both queues
	typedef enum logic [1:0] {
		QSFC_LVL_8        = 2'b00,
		QSFC_LVL_16       = 2'b01,
		QSFC_LVL_24       = 2'b10,
		QSFC_LVL_RESERVED = 2'b11
	} qsfc_level_type;

	// Chip select sequencer states
	typedef enum logic [1:0] {
		QSFC_CS_GAP   = 2'b00,
		QSFC_CS_READY = 2'b01,
		QSFC_CS_ON    = 2'b10
	} qsfc_cs_type;

endpackage : qsfc_pkg

`default_nettype wire

// file: include/qsfc_fifo_if.sv
// Purpose: Push/pop bundle between the register block and one queue
// Assumes: Single clock, push and pop are one-cycle strobes
// Notes:   Count width fits DEPTH itself
`default_nettype none

interface qsfc_fifo_if #(
	parameter int WIDTH = 32,
	parameter int CW    = 6
);
	logic             push;       // Write strobe
	logic [WIDTH-1:0] push_data;  // Word to store
	logic             pop;        // Read strobe
	logic [WIDTH-1:0] pop_data;   // Head word
	logic [CW-1:0]    count;      // Words held
	logic             full;       // No room
	logic             empty;      // Nothing held

	modport store (input push, push_data, pop, output pop_data, count, full, empty);
	modport user  (output push, push_data, pop, input pop_data, count, full, empty);
endinterface : qsfc_fifo_if

`default_nettype wire

// file: rtl/qsfc_fifo.sv
// Purpose: Word queue used for transmit and receive data
// Assumes: Pushes to a full queue and pops of an empty one are dropped by the queue itself
// Notes:   Head word is read straight from the array
`default_nettype none

module qsfc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int CW    = 6
) (
	input  wire logic   ref_clk,
	input  wire logic   rst_n,
	qsfc_fifo_if.store  port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage
	logic [AW-1:0]    wr_ptr;       // Next write slot
	logic [AW-1:0]    rd_ptr;       // Head slot
	logic [CW-1:0]    count;        // Occupancy

	wire do_push = port.push & ~port.full;   // Guarded write
	wire do_pop  = port.pop & ~port.empty;   // Guarded read

	assign port.pop_data = mem[rd_ptr];
	assign port.count    = count;
	assign port.full     = (count == CW'(DEPTH));
	assign port.empty    = (count == '0);

	// ---------------------------------------------------------------
	// Pointers and occupancy
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end

	// Array write, no reset needed for data
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= port.push_data;
		end
	end
endmodule : qsfc_fifo

`default_nettype wire

// file: verif/qsfc_assertions.sv
// Purpose: Port-level checks of the flash register block
// Assumes: One clock, synchronous active-low reset
// Notes:   Mirrors of two written registers judge the outputs
`default_nettype none

module qsfc_assertions (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        dma_rx_req,
	input wire logic        dma_tx_req,
	input wire logic        cmd_done,
	input wire logic        cs_request,
	input wire logic        cs_granted,
	input wire logic        cs_n,
	input wire logic [31:0] sys_addr,
	input wire logic [31:0] flash_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// Mirrors of software writes
	// ---------------------------------------------------------------
	wire         wr_acc  = psel & penable & pwrite;      // Write lands here
	wire         ctl_wr  = wr_acc & (paddr == 12'h020);  // Enables written
	wire         trim_wr = wr_acc & (paddr == 12'h02C);  // Mask written
	logic [31:0] trim_m;                                 // Copy of mask
	logic [1:0]  ctl_m;                                  // Copy of enables
	// Follow the same edge the block uses
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			trim_m <= 32'h0000_0000;
			ctl_m  <= 2'h0;
		end else begin
			if (trim_wr) trim_m <= pwdata;
			if (ctl_wr) ctl_m <= pwdata[1:0];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	pready_a: assert property (pready == (psel && penable))
		else $error("pready not tied to access phase");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	unmapped_a: assert property (psel && penable && !pwrite && paddr == 12'h004
		|-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
	irq_gate_a: assert property (irq |-> ctl_m[1])
		else $error("irq without enable");
	done_irq_a: assert property (cmd_done && ctl_m[1] |=> irq)
		else $error("irq missing after command done");
	dma_gate_a: assert property (dma_rx_req || dma_tx_req |-> ctl_m[0])
		else $error("dma request while disabled");
	trim_use_a: assert property (flash_addr == ($past(sys_addr) & $past(trim_m)))
		else $error("flash address not masked");
	cs_drop_a: assert property (cs_granted && !cs_request |=> cs_n)
		else $error("chip select held after release");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*2])
		else $error("chip select gap too short");
	cs_pair_a: assert property (cs_granted |-> !cs_n)
		else $error("grant without chip select");
endmodule : qsfc_assertions

`default_nettype wire

// file: verif/qsfc_engine_model.sv
// Purpose: Serial engine and flash side seen by the register block
// Assumes: Tasks are entered just after a rising edge
// Notes:   Serial clock runs free since the gap is counted on it
`default_nettype none

module qsfc_engine_model (
	input wire logic   ref_clk,
	input wire logic   cs_granted,
	output logic       cmd_done,
	output logic       status_valid,
	output logic [7:0] status_byte,
	output logic       final_data,
	output logic       rx_push,
	output logic [31:0] rx_data,
	output logic       tx_pop,
	output logic       cs_request,
	output logic       sck_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle levels, then an 800 ns link clock off the ref_clk phase
	initial begin
		{cmd_done, status_valid, final_data, rx_push, tx_pop, cs_request} = 6'h00;
		status_byte = 8'h00;
		rx_data     = 32'h0000_0000;
		sck_in      = 1'b0;
		#137;
		forever #400 sck_in = ~sck_in;
	end
	// One-cycle strobe: 0 done, 1 status, 2 receive push, 3 transmit pop
	task automatic put(input logic [1:0] k, input logic [31:0] v);
		cmd_done     <= (k == 2'h0);
		status_valid <= (k == 2'h1);
		rx_push      <= (k == 2'h2);
		tx_pop       <= (k == 2'h3);
		status_byte  <= v[7:0];
		rx_data      <= v;
		@(posedge ref_clk);
		{cmd_done, status_valid, rx_push, tx_pop} <= 4'h0;
		// Released data lines never keep the last value
		status_byte  <= ~v[7:0];
		rx_data      <= ~v;
		@(posedge ref_clk);
	endtask : put
	// Mark the tail of a receive stream
	task automatic tail(input logic v);
		final_data <= v;
		@(posedge ref_clk);
	endtask : tail
	// Frame, release, ask again; gap is cycles until the next grant
	task automatic cs_cycle(output int gap);
		cs_request <= 1'b1;
		while (cs_granted !== 1'b1) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		cs_request <= 1'b0;
		@(posedge ref_clk);
		// Grant still reads high at the release edge, so step before polling
		cs_request <= 1'b1;
		gap = 0;
		do begin
			@(posedge ref_clk);
			gap++;
		end while (cs_granted !== 1'b1);
		cs_request <= 1'b0;
		@(posedge ref_clk);
	endtask : cs_cycle
endmodule : qsfc_engine_model

`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench of the flash register block
// Assumes: APB master here, engine model on the far side
// Notes:   Reads note expectations; a monitor compares them
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic        dma_rx_req, dma_tx_req, cmd_done, status_valid, final_data, rx_push;
	logic        rx_full, tx_pop, tx_empty, cs_request, cs_granted, sck_in, cs_n;
	logic [11:0] paddr;
	logic [7:0]  status_byte;
	logic [31:0] pwdata, prdata, rx_data, tx_data, sys_addr, flash_addr, w;
	logic [32:0] exp_q[$];   // Expected {pslverr, prdata}
	logic [31:0] words[$];   // Words in flight
	int          n_mismatch, total_checks, g, gap;

	qsfc_regs i_qsfc_regs (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .irq, .dma_rx_req, .dma_tx_req, .cmd_done,
		.status_valid, .status_byte, .final_data, .rx_push, .rx_data, .rx_full, .tx_pop,
		.tx_data, .tx_empty, .cs_request, .cs_granted, .sck_in, .cs_n, .sys_addr,
		.flash_addr);
	qsfc_engine_model i_qsfc_engine_model (.ref_clk, .cs_granted, .cmd_done, .status_valid,
		.status_byte, .final_data, .rx_push, .rx_data, .tx_pop, .cs_request, .sck_in);

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic lvl(input logic s, input logic e);
		check({32'h0, s}, {32'h0, e});
	endtask : lvl
	task automatic close_out();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// Setup, then access held until pready; an idle cycle follows
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	// Monitor: oldest note against each completed read
	always @(posedge ref_clk)
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
			check({pslverr, prdata}, exp_q.pop_front());
	// Hang guard
	initial begin
		#3_000_000;
		n_mismatch++;
		close_out();
	end
	initial begin
		{psel, penable, pwrite, rst_n} = 4'h0;
		paddr    = 12'h000;
		pwdata   = 32'h0000_0000;
		sys_addr = 32'h0000_0000;
		g = $urandom(78);
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(12'h014, 33'h0F);
		rd(12'h018, 33'h01);
		rd(12'h020, 33'h00);
		rd(12'h024, 33'h00);
		rd(12'h028, 33'h00);
		rd(12'h02C, 33'h00);
		rd(12'h004, 33'h1_0000_0000);
		rd(12'h100, 33'h1_0000_0000);
		w = $urandom;
		apb(1'b1, 12'h02C, w);
		sys_addr <= $urandom;
		rd(12'h02C, {1'b0, w});
		check({1'b0, flash_addr}, {1'b0, sys_addr & w});
		i_qsfc_engine_model.put(2'h1, w);
		rd(12'h028, {25'h0, w[7:0]});
		apb(1'b1, 12'h020, 32'h2);
		i_qsfc_engine_model.put(2'h0, 32'h0);
		lvl(irq, 1'b1);
		apb(1'b1, 12'h024, 32'h1);
		rd(12'h024, 33'h1);
		apb(1'b1, 12'h024, 32'h0);
		lvl(irq, 1'b0);
		apb(1'b1, 12'h020, 32'h0);
		i_qsfc_engine_model.put(2'h0, 32'h0);
		lvl(irq, 1'b0);
		rd(12'h024, 33'h1);
		// Receive queue to 16, every trigger code, then full and drained
		for (int k = 0; k < 33; k++) begin
			w = $urandom;
			if (k < 32) words.push_back(w);
			i_qsfc_engine_model.put(2'h2, w);
			if (k == 15) begin
				for (int c = 0; c < 4; c++) begin
					apb(1'b1, 12'h020, 32'((c << 12) | (c << 8) | 1));
					lvl(dma_rx_req, c < 2);
					lvl(dma_tx_req, c < 3);
				end
				apb(1'b1, 12'h020, 32'h0);
				lvl(dma_tx_req, 1'b0);
			end
		end
		lvl(rx_full, 1'b1);
		rd(12'h018, 33'h3);
		foreach (words[k]) rd(12'h100, {1'b0, words[k]});
		rd(12'h100, 33'h1_0000_0000);
		w = $urandom;
		i_qsfc_engine_model.put(2'h2, w);
		i_qsfc_engine_model.tail(1'b1);
		rd(12'h018, 33'h3);
		rd(12'h100, {1'b0, w});
		rd(12'h018, 33'h1);
		// Transmit words reach the engine in order
		words.delete();
		for (int k = 0; k < 3; k++) begin
			w = $urandom;
			words.push_back(w);
			apb(1'b1, 12'h100, w);
		end
		rd(12'h018, 33'h0);
		foreach (words[k]) begin
			check({1'b0, tx_data}, {1'b0, words[k]});
			i_qsfc_engine_model.put(2'h3, 32'h0);
		end
		lvl(tx_empty, 1'b1);
		rd(12'h018, 33'h1);
		// Shortest chip-select gap and a gap field of 3
		for (int k = 0; k < 2; k++) begin
			g = k * 3;
			apb(1'b1, 12'h014, 32'(g));
			rd(12'h014, 33'(g));
			i_qsfc_engine_model.cs_cycle(gap);
			// Field plus one periods of 8 cycles, sync and grant lag, phase slack
			lvl(gap >= g * 8 + 4 && gap <= g * 8 + 11, 1'b1);
		end
		close_out();
	end
endmodule : testbench

bind qsfc_regs qsfc_assertions i_qsfc_assertions (.ref_clk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq, .dma_rx_req, .dma_tx_req,
	.cmd_done, .cs_request, .cs_granted, .cs_n, .sys_addr, .flash_addr);

`default_nettype wire
